// file: shared/trao_pkg.sv
/*
 * Shared constants for the temperature result and alarm block: register
 * pointers, field positions, reset values, link timing and host map.
 * Assumes a single 250 MHz system clock at both ends.
 */
package trao_pkg;
   // ************************************************************
   // Device registers
   // ************************************************************
   localparam int MEAS_W = 11;
   localparam int LIM_W = 9;
   localparam logic [1:0] PTR_MEAS = 2'h0;
   localparam logic [1:0] PTR_SETUP = 2'h1;
   localparam logic [1:0] PTR_LOWER = 2'h2;
   localparam logic [1:0] PTR_UPPER = 2'h3;
   localparam int SET_SHDN = 0;
   localparam int SET_MODE = 1;
   localparam int SET_POL = 2;
   localparam int SET_FQ_LO = 3;
   localparam logic [7:0] SETUP_RST = 8'h00;
   localparam logic [8:0] UPPER_RST = 9'h0A0;
   localparam logic [8:0] LOWER_RST = 9'h096;
   localparam logic [2:0] FQ_NEED0 = 3'h1;
   localparam logic [2:0] FQ_NEED1 = 3'h2;
   localparam logic [2:0] FQ_NEED2 = 3'h4;
   localparam logic [2:0] FQ_NEED3 = 3'h6;
   localparam logic [6:0] CMD_HI = 7'h00;
   // ************************************************************
   // Link timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int LINK_PERIOD_NS = 64;
   localparam int SCL_QUARTER = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // ************************************************************
   // Host register map
   // ************************************************************
   localparam logic [7:0] HREG_CTRL = 8'h00;
   localparam logic [7:0] HREG_WDATA = 8'h04;
   localparam logic [7:0] HREG_STAT = 8'h08;
   localparam logic [7:0] HREG_RDATA = 8'h0C;
   localparam int CTL_GO = 0;
   localparam int CTL_RD = 1;
   localparam int CTL_PTR_LO = 2;
   localparam int CTL_NB_LO = 4;
endpackage

// file: shared/trao_if.sv
/*
 * Link between host and device: serial clock, open-drain data line and
 * open-drain alarm line, resolved here from the drivers' enables.
 * Assumes pull-ups: a released line reads high.
 */
interface trao_if;
   logic scl;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic alarm_dev_o;
   logic alarm_dev_oe;
   wire logic sda;
   wire logic alarm;

   assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
   assign alarm = ~(alarm_dev_oe & ~alarm_dev_o);

   modport host (
      output scl,
      output sda_host_o,
      output sda_host_oe,
      input sda,
      input alarm
   );
   modport dev (
      input scl,
      input sda,
      output sda_dev_o,
      output sda_dev_oe,
      output alarm_dev_o,
      output alarm_dev_oe
   );
endinterface

// file: verilog/trao_sync.sv
/*
 * Two-flop synchroniser for link pins entering the mclk_i domain.
 * Assumes idle-high lines; both stages reset high.
 */
module trao_sync #(
   parameter int W = 2
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule // trao_sync

// file: verilog/trao_dev.sv
/*
 * Device end: measured value, setup and limit registers behind a serial
 * register port, comparison at each conversion and open-drain alarm pin.
 * Assumes conversion results arrive as pulses on mclk_i and the host
 * makes the serial clock; link pins are synchronised before use.
 */
module trao_dev (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   trao_if.dev link,
   input wire logic conv_done_i,
   input wire logic [trao_pkg::MEAS_W-1:0] conv_result_i,
   output logic shutdown_o,
   output logic alarm_active_o
);
   typedef enum logic [2:0] {
      DS_IDLE = 3'b000,
      DS_RX = 3'b001,
      DS_RACK = 3'b010,
      DS_TX = 3'b011,
      DS_MACK = 3'b100
   } trao_dst_t;

   // ************************************************************
   // Pin synchronisation and bus conditions
   // ************************************************************
   logic [1:0] pin_s;
   logic scl_q_reg;
   logic sda_q_reg;
   wire scl_s = pin_s[1];
   wire sda_s = pin_s[0];
   trao_sync #(.W(2)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i({link.scl, link.sda}),
      .q_o(pin_s)
   );

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         scl_q_reg <= 1'h1;
         sda_q_reg <= 1'h1;
      end else begin
         scl_q_reg <= scl_s;
         sda_q_reg <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_q_reg;
   wire scl_fall = ~scl_s & scl_q_reg;
   wire start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
   wire stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

   // ************************************************************
   // Registers
   // ************************************************************
   trao_dst_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [1:0] byte_idx_reg;
   logic rw_reg;
   logic tx_sel_reg;
   logic sda_oe_reg;
   logic [1:0] ptr_reg;
   logic [7:0] hi_hold_reg;
   logic [15:0] snap_reg;
   logic [7:0] setup_reg;
   logic [8:0] upper_reg;
   logic [8:0] lower_reg;
   logic [10:0] meas_reg;

   wire shdn = setup_reg[trao_pkg::SET_SHDN];
   wire int_mode = setup_reg[trao_pkg::SET_MODE];
   wire pol = setup_reg[trao_pkg::SET_POL];
   wire [1:0] fq_code = setup_reg[trao_pkg::SET_FQ_LO +: 2];

   // Byte complete on the falling edge after the eighth bit
   wire rx_take = (state_reg == DS_RX) && scl_fall && (bit_cnt_reg == 4'h8);
   wire cmd_byte = rx_take && (byte_idx_reg == 2'h0);
   wire rd_evt = cmd_byte && shift_reg[0];
   wire wr_data = rx_take && !rw_reg && byte_idx_reg[1];
   wire wr_first = wr_data && (byte_idx_reg == 2'h2);
   wire wr_second = wr_data && (byte_idx_reg == 2'h3);
   wire wr_setup = wr_first && (ptr_reg == trao_pkg::PTR_SETUP);
   wire wr_upper = wr_second && (ptr_reg == trao_pkg::PTR_UPPER);
   wire wr_lower = wr_second && (ptr_reg == trao_pkg::PTR_LOWER);

   // Read image of each register, most significant bits first
   wire [15:0] meas_img = {meas_reg, 5'h00};
   wire [15:0] upper_img = {upper_reg, 7'h00};
   wire [15:0] lower_img = {lower_reg, 7'h00};
   wire [15:0] rd_img = (ptr_reg == trao_pkg::PTR_MEAS) ? meas_img :
                        (ptr_reg == trao_pkg::PTR_SETUP) ? {setup_reg, setup_reg} :
                        (ptr_reg == trao_pkg::PTR_LOWER) ? lower_img : upper_img;
   wire [7:0] tx_byte = tx_sel_reg ? snap_reg[7:0] : snap_reg[15:8];

   // ************************************************************
   // Serial register port
   // ************************************************************
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_reg <= DS_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_idx_reg <= 2'h0;
         rw_reg <= 1'h0;
         tx_sel_reg <= 1'h0;
         sda_oe_reg <= 1'h0;
         ptr_reg <= trao_pkg::PTR_MEAS;
         snap_reg <= 16'h0000;
      end else if (start_det) begin
         state_reg <= DS_RX;
         bit_cnt_reg <= 4'h0;
         byte_idx_reg <= 2'h0;
         sda_oe_reg <= 1'h0;
      end else if (stop_det) begin
         state_reg <= DS_IDLE;
         sda_oe_reg <= 1'h0;
      end else begin
         case (state_reg)
            DS_RX: begin
               if (scl_rise && bit_cnt_reg != 4'h8) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (rx_take) begin
                  state_reg <= DS_RACK;
                  sda_oe_reg <= 1'h1;
                  if (byte_idx_reg != 2'h3) byte_idx_reg <= byte_idx_reg + 2'h1;
                  if (cmd_byte) begin
                     rw_reg <= shift_reg[0];
                     tx_sel_reg <= 1'h0;
                     // One snapshot per read keeps both bytes coherent
                     snap_reg <= rd_img;
                  end
                  if (!rw_reg && byte_idx_reg == 2'h1) ptr_reg <= shift_reg[1:0];
               end
            end
            DS_RACK: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h1;
                  if (rw_reg) begin
                     state_reg <= DS_TX;
                     shift_reg <= tx_byte;
                     sda_oe_reg <= ~tx_byte[7];
                     tx_sel_reg <= ~tx_sel_reg;
                  end else begin
                     state_reg <= DS_RX;
                     bit_cnt_reg <= 4'h0;
                     sda_oe_reg <= 1'h0;
                  end
               end
            end
            DS_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == 4'h8) begin
                     state_reg <= DS_MACK;
                     sda_oe_reg <= 1'h0;
                  end else begin
                     sda_oe_reg <= ~shift_reg[6];
                     shift_reg <= {shift_reg[6:0], 1'h0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            DS_MACK: begin
               if (scl_rise && sda_s) begin
                  // No acknowledge: the read may stop after any byte
                  state_reg <= DS_IDLE;
               end else if (scl_fall) begin
                  state_reg <= DS_TX;
                  shift_reg <= tx_byte;
                  sda_oe_reg <= ~tx_byte[7];
                  tx_sel_reg <= ~tx_sel_reg;
                  bit_cnt_reg <= 4'h1;
               end
            end
            default: begin
               state_reg <= DS_IDLE;
               sda_oe_reg <= 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         setup_reg <= trao_pkg::SETUP_RST;
         upper_reg <= trao_pkg::UPPER_RST;
         lower_reg <= trao_pkg::LOWER_RST;
         hi_hold_reg <= 8'h00;
      end else begin
         if (wr_first) hi_hold_reg <= shift_reg;
         if (wr_setup) setup_reg <= shift_reg;
         // Limit commits on its low byte so a half write never compares
         if (wr_upper) upper_reg <= {hi_hold_reg, shift_reg[7]};
         if (wr_lower) lower_reg <= {hi_hold_reg, shift_reg[7]};
      end
   end

   // ************************************************************
   // Conversion result and alarm
   // ************************************************************
   logic eval_reg;
   logic side_reg;
   logic int_reg;
   logic [2:0] fcnt_reg;
   logic alarm_oe_reg;
   logic alarm_act_reg;

   wire conv_take = conv_done_i & ~shdn;
   wire over = $signed(meas_reg[10:2]) > $signed(upper_reg);
   wire under = $signed(meas_reg[10:2]) < $signed(lower_reg);
   // Side clear looks for over limit, side set looks for under limit
   wire trip = side_reg ? under : over;
   wire [2:0] fq_need = (fq_code == 2'h0) ? trao_pkg::FQ_NEED0 :
                        (fq_code == 2'h1) ? trao_pkg::FQ_NEED1 :
                        (fq_code == 2'h2) ? trao_pkg::FQ_NEED2 : trao_pkg::FQ_NEED3;
   wire [2:0] fcnt_inc = fcnt_reg + 3'h1;
   wire fire = eval_reg && trip && (fcnt_inc >= fq_need);
   wire active = int_mode ? int_reg : side_reg;
   wire level = pol ? active : ~active;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meas_reg <= 11'h000;
         eval_reg <= 1'h0;
         side_reg <= 1'h0;
         int_reg <= 1'h0;
         fcnt_reg <= 3'h0;
         alarm_oe_reg <= 1'h0;
         alarm_act_reg <= 1'h0;
      end else begin
         if (conv_take) meas_reg <= conv_result_i;
         eval_reg <= conv_take;
         if (eval_reg) fcnt_reg <= (trip && !fire) ? fcnt_inc : 3'h0;
         if (fire) side_reg <= ~side_reg;
         // Clear first so a trip in the same cycle wins
         if (rd_evt || (int_mode && shdn)) int_reg <= 1'h0;
         if (fire && int_mode) int_reg <= 1'h1;
         alarm_oe_reg <= ~level;
         alarm_act_reg <= active;
      end
   end

   assign link.sda_dev_o = 1'h0;
   assign link.sda_dev_oe = sda_oe_reg;
   assign link.alarm_dev_o = 1'h0;
   assign link.alarm_dev_oe = alarm_oe_reg;
   assign shutdown_o = shdn;
   assign alarm_active_o = alarm_act_reg;
endmodule // trao_dev

// file: verilog/trao_host.sv
/*
 * Host end: APB slave registers that order serial register transfers to
 * the device, a serial clock made by division of mclk_i, and status.
 * Assumes software sets the pointer with a write of zero data bytes
 * before reading a different register.
 */
module trao_host #(
   parameter int QUARTER = trao_pkg::SCL_QUARTER
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   trao_if.host link
);
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_START = 2'b01,
      HS_BIT = 2'b10,
      HS_STOP = 2'b11
   } trao_hst_t;

   // ************************************************************
   // Pins and divider
   // ************************************************************
   logic [1:0] pin_s;
   logic [7:0] div_reg;

   trao_sync #(.W(2)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i({link.sda, link.alarm}),
      .q_o(pin_s)
   );

   wire sda_s = pin_s[1];
   wire alarm_s = pin_s[0];
   wire tick = (div_reg == 8'(QUARTER - 1));

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   trao_hst_t state_reg;
   logic rd_reg;
   logic [1:0] ptr_reg;
   logic [1:0] nb_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rx_reg;
   logic nack_reg;
   logic [31:0] prdata_reg;

   wire busy = (state_reg != HS_IDLE);
   wire hit_ctrl = (paddr_i == trao_pkg::HREG_CTRL);
   wire hit_wdata = (paddr_i == trao_pkg::HREG_WDATA);
   wire hit_stat = (paddr_i == trao_pkg::HREG_STAT);
   wire hit_rdata = (paddr_i == trao_pkg::HREG_RDATA);
   wire hit = hit_ctrl | hit_wdata | hit_stat | hit_rdata;
   wire access = psel_i & penable_i;
   wire wr = access & pwrite_i;
   // Orders arriving while busy are dropped; poll the busy bit first
   wire go = wr & hit_ctrl & pwdata_i[trao_pkg::CTL_GO] & ~busy;
   wire [31:0] rd_mux = hit_ctrl ? {26'h0, nb_reg, ptr_reg, rd_reg, 1'h0} :
                        hit_wdata ? {16'h0, wdata_reg} :
                        hit_stat ? {29'h0, alarm_s, nack_reg, busy} :
                        hit_rdata ? {16'h0, rx_reg} : 32'h0;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         prdata_reg <= 32'h0;
      end else if (psel_i && !penable_i) begin
         prdata_reg <= rd_mux;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = 1'h1;
   assign pslverr_o = access & ~hit;

   // ************************************************************
   // Serial transfer engine
   // ************************************************************
   logic [1:0] q_reg;
   logic [3:0] bit_reg;
   logic [1:0] byte_reg;
   logic scl_reg;
   logic sda_oe_reg;

   wire is_rx = rd_reg && (byte_reg != 2'h0);
   wire [1:0] last_idx = rd_reg ? nb_reg : nb_reg + 2'h1;
   wire last_byte = (byte_reg == last_idx);
   wire [7:0] tx_byte = (byte_reg == 2'h0) ? {trao_pkg::CMD_HI, rd_reg} :
                        (byte_reg == 2'h1) ? {6'h00, ptr_reg} :
                        (byte_reg == 2'h2) ? wdata_reg[15:8] : wdata_reg[7:0];
   wire cur_bit = tx_byte[~bit_reg[2:0]];
   wire ack_slot = (bit_reg == 4'h8);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_reg <= HS_IDLE;
         q_reg <= 2'h0;
         bit_reg <= 4'h0;
         byte_reg <= 2'h0;
         scl_reg <= 1'h1;
         sda_oe_reg <= 1'h0;
         rd_reg <= 1'h0;
         ptr_reg <= 2'h0;
         nb_reg <= 2'h0;
         wdata_reg <= 16'h0000;
         rx_reg <= 16'h0000;
         nack_reg <= 1'h0;
      end else begin
         if (wr && hit_wdata && !busy) begin
            wdata_reg <= pwdata_i[15:0];
         end
         if (go) begin
            state_reg <= HS_START;
            q_reg <= 2'h0;
            rd_reg <= pwdata_i[trao_pkg::CTL_RD];
            ptr_reg <= pwdata_i[trao_pkg::CTL_PTR_LO +: 2];
            nb_reg <= pwdata_i[trao_pkg::CTL_NB_LO +: 2];
            nack_reg <= 1'h0;
            rx_reg <= 16'h0000;
         end else if (busy && tick) begin
            q_reg <= q_reg + 2'h1;
            case (state_reg)
               HS_START: begin
                  if (q_reg == 2'h1) sda_oe_reg <= 1'h1;
                  if (q_reg == 2'h2) scl_reg <= 1'h0;
                  if (q_reg == 2'h3) begin
                     state_reg <= HS_BIT;
                     bit_reg <= 4'h0;
                     byte_reg <= 2'h0;
                  end
               end
               HS_BIT: begin
                  if (q_reg == 2'h0) begin
                     // Acknowledge every byte read except the last
                     sda_oe_reg <= ack_slot ? (is_rx & ~last_byte) : (~is_rx & ~cur_bit);
                  end
                  if (q_reg == 2'h1) scl_reg <= 1'h1;
                  if (q_reg == 2'h2) begin
                     if (!ack_slot && is_rx) begin
                        // Sign lands in bit 15 for software after a two-byte read
                        rx_reg <= {rx_reg[14:0], sda_s};
                     end
                     if (ack_slot && !is_rx && sda_s) nack_reg <= 1'h1;
                  end
                  if (q_reg == 2'h3) begin
                     scl_reg <= 1'h0;
                     bit_reg <= ack_slot ? 4'h0 : bit_reg + 4'h1;
                     if (ack_slot && (last_byte || nack_reg)) begin
                        state_reg <= HS_STOP;
                     end else if (ack_slot) begin
                        byte_reg <= byte_reg + 2'h1;
                     end
                  end
               end
               HS_STOP: begin
                  if (q_reg == 2'h0) sda_oe_reg <= 1'h1;
                  if (q_reg == 2'h1) scl_reg <= 1'h1;
                  if (q_reg == 2'h2) sda_oe_reg <= 1'h0;
                  if (q_reg == 2'h3) state_reg <= HS_IDLE;
               end
               default: state_reg <= HS_IDLE;
            endcase
         end
      end
   end

   // Limit ordering is software's duty; the engine writes what it is given
   assign link.scl = scl_reg;
   assign link.sda_host_o = 1'h0;
   assign link.sda_host_oe = sda_oe_reg;
endmodule // trao_host

// file: tb/trao_checker.sv
/* Checker for the serial link and the alarm pin of the two ends.
   Assumes the host QUARTER of 4, so each scl phase lasts at least 8 clocks. */
module trao_checker (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic scl,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic alarm_dev_o,
   input wire logic alarm_dev_oe,
   input wire logic sda,
   input wire logic alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   alarm_open_drain_a: assert property (alarm_dev_oe |-> !alarm_dev_o)
      else $error("alarm pin driven high");
   dev_open_drain_a: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("device drives sda high");
   host_open_drain_a: assert property (sda_host_oe |-> !sda_host_o)
      else $error("host drives sda high");
   reset_idle_a: assert property ($rose(rst_n_i) |-> scl && !sda_dev_oe && !alarm_dev_oe)
      else $error("link not idle after reset");
   dev_hold_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
      else $error("device changed sda while scl high");
   scl_high_a: assert property ($rose(scl) |-> scl [*8])
      else $error("scl high phase short");
   scl_low_a: assert property ($fell(scl) |-> !scl [*8])
      else $error("scl low phase short");
   no_clash_a: assert property (scl && sda_dev_oe |-> !sda_host_oe)
      else $error("both ends drive sda");
   cover property ($fell(alarm));
   cover property ($rose(alarm));
   cover property (scl && $fell(sda));
endmodule // trao_checker

// file: tb/tb_top.sv
/* Testbench: both ends joined by the link, host ordered over APB.
   Assumes host QUARTER default and zero-wait APB answers. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
   logic pwrite_i = 1'h0, conv_done_i = 1'h0, err;
   logic pready_o, pslverr_o, shutdown_o, alarm_active_o;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, r;
   logic [10:0] conv_result_i = 11'h000;
   logic [15:0] q;
   int mismatches = 0, n_tests = 0, cyc = 0;
   int need[4] = '{1, 2, 4, 6};
   trao_if link ();
   trao_host trao_host_inst (.mclk_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link);
   trao_dev trao_dev_inst (.mclk_i, .rst_n_i, .link, .conv_done_i, .conv_result_i,
      .shutdown_o, .alarm_active_o);
   trao_checker trao_checker_inst (.mclk_i, .rst_n_i, .scl(link.scl),
      .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o),
      .sda_dev_oe(link.sda_dev_oe), .alarm_dev_o(link.alarm_dev_o),
      .alarm_dev_oe(link.alarm_dev_oe), .sda(link.sda), .alarm(link.alarm));
   initial forever #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 80000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("Counts: %0d mismatches, %0d compares", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'h1;
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'h1;
      do @(posedge mclk_i); while (pready_o !== 1'h1);
      r = prdata_o;
      err = pslverr_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
      @(posedge mclk_i);
   endtask
   // Host only reads back what the device sent once busy drops
   task automatic xfer(input logic rd, input logic [1:0] p, input logic [1:0] nb,
      input logic [15:0] wd);
      apb(1'h1, trao_pkg::HREG_WDATA, {16'h0, wd});
      apb(1'h1, trao_pkg::HREG_CTRL, {26'h0, nb, p, rd, 1'h1});
      do apb(1'h0, trao_pkg::HREG_STAT, 32'h0); while (r[0] !== 1'h0);
      chk({15'h0, r[1]}, 16'h0000);
      apb(1'h0, trao_pkg::HREG_RDATA, 32'h0);
      q = r[15:0];
   endtask
   task automatic rchk(input logic [1:0] p, input logic [1:0] nb, input logic [15:0] e);
      xfer(1'h0, p, 2'h0, 16'h0);
      xfer(1'h1, p, nb, 16'h0);
      chk(q, e);
   endtask
   task automatic al(input logic a, input logic p);
      chk({15'h0, alarm_active_o}, {15'h0, a});
      chk({15'h0, link.alarm}, {15'h0, ~(a ^ p)});
      apb(1'h0, trao_pkg::HREG_STAT, 32'h0);
      chk({15'h0, r[2]}, {15'h0, ~(a ^ p)});
   endtask
   task automatic cv(input logic [10:0] v, input logic a, input logic p);
      conv_done_i <= 1'h1;
      conv_result_i <= v;
      @(posedge mclk_i);
      conv_done_i <= 1'h0;
      repeat (4) @(posedge mclk_i);
      al(a, p);
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'h1;
      @(posedge mclk_i);
      al(1'h0, 1'h0);
      rchk(2'h3, 2'h2, 16'h5000);
      rchk(2'h2, 2'h2, 16'h4B00);
      rchk(2'h1, 2'h1, 16'h0000);
      apb(1'h0, 8'h10, 32'h0);
      chk({err, r[14:0]}, 16'h8000);
      cv(11'h25F, 1'h0, 1'h0);
      rchk(2'h0, 2'h2, 16'h4BE0);
      rchk(2'h0, 2'h1, 16'h004B);
      cv(11'h283, 1'h0, 1'h0);
      cv(11'h284, 1'h1, 1'h0);
      rchk(2'h1, 2'h1, 16'h0000);
      al(1'h1, 1'h0);
      cv(11'h258, 1'h1, 1'h0);
      cv(11'h254, 1'h0, 1'h0);
      xfer(1'h0, 2'h1, 2'h1, 16'h0400);
      al(1'h0, 1'h1);
      cv(11'h284, 1'h1, 1'h1);
      cv(11'h254, 1'h0, 1'h1);
      xfer(1'h0, 2'h1, 2'h1, 16'h0200);
      cv(11'h284, 1'h1, 1'h0);
      cv(11'h284, 1'h1, 1'h0);
      rchk(2'h1, 2'h1, 16'h0002);
      al(1'h0, 1'h0);
      cv(11'h284, 1'h0, 1'h0);
      cv(11'h254, 1'h1, 1'h0);
      for (int k = 0; k < 4; k++) begin
         xfer(1'h0, 2'h1, 2'h1, {3'h0, k[1:0], 11'h000});
         for (int i = 0; i < need[k]; i++) cv(11'h284, i == need[k] - 1, 1'h0);
         for (int i = 0; i < need[k]; i++) cv(11'h254, i != need[k] - 1, 1'h0);
      end
      xfer(1'h0, 2'h1, 2'h1, 16'h0200);
      cv(11'h284, 1'h1, 1'h0);
      xfer(1'h0, 2'h1, 2'h1, 16'h0300);
      al(1'h0, 1'h0);
      chk({15'h0, shutdown_o}, 16'h0001);
      xfer(1'h0, 2'h1, 2'h1, 16'h0100);
      cv(11'h254, 1'h1, 1'h0);
      xfer(1'h0, 2'h1, 2'h1, 16'h0000);
      xfer(1'h0, 2'h3, 2'h2, 16'h19FF);
      rchk(2'h3, 2'h2, 16'h1980);
      xfer(1'h0, 2'h2, 2'h2, 16'hE700);
      rchk(2'h2, 2'h2, 16'hE700);
      cv(11'h648, 1'h0, 1'h0);
      rchk(2'h0, 2'h2, 16'hC900);
      finish_test();
   end
endmodule // tb_top
